// >>> bench/shis_host_model.sv
// host-side serial master model for the interface select bench
`timescale 1ns/100ps
module shis_host_model (
    output reg sck,
    output reg csA,
    output reg csG,
    output reg csM,
    output reg hostD,
    output reg hostOe,
    input wire amLine,
    input wire gLine,
    input wire sdLine
);
    // idle: selects high, clock parked low, data released
    initial
    begin
        {csA, csG, csM, sck, hostD, hostOe} = 6'b111000;
    end
    // one framed transfer of nb data bytes; launch on fall, sample on rise
    task xfer(input [2:0] sel, input cpol, input tw, input [7:0] cmd, input [15:0] wd, input int nb,
              output [15:0] rd);
        int i;
        begin
            rd = 16'h0;
            sck = cpol;
            {csM, csG, csA} = ~sel;
            #400;
            for (i = 0; i < 8 + 8 * nb; i++)
            begin
                sck = 1'b0;
                hostOe = !(cmd[7] && i >= 8);
                hostD = (i < 8) ? cmd[7 - i] : wd[15 - (i - 8)];
                #200;
                rd = {rd[14:0], tw ? sdLine : sel[1] ? gLine : amLine};
                sck = 1'b1;
                #200;
            end
            sck = cpol;
            #200;
            {csA, csG, csM, hostOe} = 4'b1110;
            #400;
        end
    endtask
endmodule // shis_host_model

// >>> bench/shis_host_select_checker.sv
// concurrent checks on the host interface select block pins
`timescale 1ns/100ps
module shis_host_select_checker (
    input wire clk,
    input wire rst,
    input wire spiMode,
    input wire [2:0] targetSel,
    input wire accel_mag_serial_out_oe,
    input wire gyro_serial_out_oe,
    input wire accelThreeWire,
    input wire gyroThreeWire,
    input wire accel_mag_serial_out_in,
    input wire accelMagAddrLsb,
    input wire magneto_select_n,
    input wire magAddrLsb,
    input wire shared_serial_data_oe,
    input wire shared_serial_data_out,
    input wire i2cSdaPullLow,
    input wire regWrStrobe,
    input wire regRdReq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_slave;
        (targetSel == 3'h0)[*3] |-> !accel_mag_serial_out_oe && !gyro_serial_out_oe;
    endproperty
    a_slave: assert property (p_slave) else $error("output driven while unselected");
    property p_fourWire;
        $fell(rst) |-> !accelThreeWire && !gyroThreeWire;
    endproperty
    a_fourWire: assert property (p_fourWire) else $error("not four-wire after reset");
    property p_threeWire;
        spiMode && accelThreeWire && gyroThreeWire |-> !accel_mag_serial_out_oe && !gyro_serial_out_oe;
    endproperty
    a_threeWire: assert property (p_threeWire) else $error("data pin driven in three-wire");
    property p_amStrap;
        (!spiMode && $stable(accel_mag_serial_out_in))[*4] |-> accelMagAddrLsb == accel_mag_serial_out_in;
    endproperty
    a_amStrap: assert property (p_amStrap) else $error("accel-mag address bit wrong");
    property p_magStrap;
        (!spiMode && $stable(magneto_select_n))[*4] |-> magAddrLsb == magneto_select_n;
    endproperty
    a_magStrap: assert property (p_magStrap) else $error("mag address bit wrong");
    property p_i2cSel;
        !spiMode && !$past(spiMode) |-> targetSel == 3'h0;
    endproperty
    a_i2cSel: assert property (p_i2cSel) else $error("select taken under I2C");
    property p_sda;
        (!spiMode && $stable(i2cSdaPullLow))[*2] |-> shared_serial_data_oe == i2cSdaPullLow && !shared_serial_data_out;
    endproperty
    a_sda: assert property (p_sda) else $error("data line drive wrong under I2C");
    property p_wr;
        regWrStrobe |-> (targetSel != 3'h0) ##1 !regWrStrobe;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe malformed");
    c_write: cover property (regWrStrobe);
    c_read: cover property (regRdReq);
    c_threeWire: cover property (shared_serial_data_oe && spiMode);
endmodule // shis_host_select_checker
bind shis_host_select shis_host_select_checker i_shis_host_select_checker (
    .clk(clk),
    .rst(rst),
    .spiMode(spiMode),
    .targetSel(targetSel),
    .accel_mag_serial_out_oe(accel_mag_serial_out_oe),
    .gyro_serial_out_oe(gyro_serial_out_oe),
    .accelThreeWire(accelThreeWire),
    .gyroThreeWire(gyroThreeWire),
    .accel_mag_serial_out_in(accel_mag_serial_out_in),
    .accelMagAddrLsb(accelMagAddrLsb),
    .magneto_select_n(magneto_select_n),
    .magAddrLsb(magAddrLsb),
    .shared_serial_data_oe(shared_serial_data_oe),
    .shared_serial_data_out(shared_serial_data_out),
    .i2cSdaPullLow(i2cSdaPullLow),
    .regWrStrobe(regWrStrobe),
    .regRdReq(regRdReq)
);

// >>> bench/tb_shis_host_select.sv
// self-checking bench for the host interface select block
`timescale 1ns/100ps
module tb_shis_host_select;
    reg clk, rst, protocol_select_pin, i2cSdaPullLow, strapAm, strapG, flt;
    wire shared_serial_clock, accel_select_n, gyro_select_n, magneto_select_n, hostD, hostOe;
    wire shared_serial_data_in, shared_serial_data_out, shared_serial_data_oe;
    wire accel_mag_serial_out_in, accel_mag_serial_out_out, accel_mag_serial_out_oe;
    wire gyro_serial_out_in, gyro_serial_out_out, gyro_serial_out_oe;
    wire [2:0] targetSel;
    wire [6:0] regAddr;
    wire [7:0] regWrData, accelRdData, gyroRdData, magRdData;
    wire regWrStrobe, regRdReq, spiMode, spiModeHigh, accelThreeWire, gyroThreeWire;
    wire i2cSclLevel, i2cSdaLevel, accelMagAddrLsb, gyroAddrLsb, magAddrLsb;
    reg [17:0] wrSeen;
    reg [9:0] rdSeen;
    reg [15:0] rd;
    int failCount = 0;
    int checksDone = 0;
    // pin levels: driver wins, else pull-up or strap under I2C, or a changing level
    assign shared_serial_data_in = shared_serial_data_oe ? shared_serial_data_out : hostOe ? hostD
                                   : protocol_select_pin ? 1'b1 : flt;
    assign accel_mag_serial_out_in = accel_mag_serial_out_oe ? accel_mag_serial_out_out : protocol_select_pin ? strapAm : flt;
    assign gyro_serial_out_in = gyro_serial_out_oe ? gyro_serial_out_out : protocol_select_pin ? strapG : flt;
    // sensor cores answer combinationally
    assign accelRdData = {1'b0, regAddr} ^ 8'h5A;
    assign gyroRdData = {1'b0, regAddr} ^ 8'h3C;
    assign magRdData = {1'b0, regAddr} ^ 8'hC3;
    shis_host_select i_shis_host_select (
        .clk(clk),
        .rst(rst),
        .protocol_select_pin(protocol_select_pin),
        .shared_serial_clock(shared_serial_clock),
        .accel_select_n(accel_select_n),
        .gyro_select_n(gyro_select_n),
        .magneto_select_n(magneto_select_n),
        .shared_serial_data_in(shared_serial_data_in),
        .shared_serial_data_out(shared_serial_data_out),
        .shared_serial_data_oe(shared_serial_data_oe),
        .accel_mag_serial_out_in(accel_mag_serial_out_in),
        .accel_mag_serial_out_out(accel_mag_serial_out_out),
        .accel_mag_serial_out_oe(accel_mag_serial_out_oe),
        .gyro_serial_out_in(gyro_serial_out_in),
        .gyro_serial_out_out(gyro_serial_out_out),
        .gyro_serial_out_oe(gyro_serial_out_oe),
        .targetSel(targetSel),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrStrobe(regWrStrobe),
        .regRdReq(regRdReq),
        .accelRdData(accelRdData),
        .gyroRdData(gyroRdData),
        .magRdData(magRdData),
        .spiMode(spiMode),
        .spiModeHigh(spiModeHigh),
        .accelThreeWire(accelThreeWire),
        .gyroThreeWire(gyroThreeWire),
        .i2cSclLevel(i2cSclLevel),
        .i2cSdaLevel(i2cSdaLevel),
        .i2cSdaPullLow(i2cSdaPullLow),
        .accelMagAddrLsb(accelMagAddrLsb),
        .gyroAddrLsb(gyroAddrLsb),
        .magAddrLsb(magAddrLsb)
    );
    shis_host_model i_shis_host_model (.sck(shared_serial_clock), .csA(accel_select_n), .csG(gyro_select_n),
        .csM(magneto_select_n), .hostD(hostD), .hostOe(hostOe), .amLine(accel_mag_serial_out_in),
        .gLine(gyro_serial_out_in), .sdLine(shared_serial_data_in));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // capture each write toward the cores; floating level toggles
    always @(posedge clk)
    begin
        if (regWrStrobe === 1'b1)
            wrSeen <= {targetSel, regAddr, regWrData};
        if (regRdReq === 1'b1)
            rdSeen <= {targetSel, regAddr};
        flt <= ~flt;
    end
    task check(input [17:0] seen, input [17:0] exp);
        begin
            checksDone++;
            if (seen !== exp)
            begin
                failCount++;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", checksDone, failCount);
            if (failCount == 0 && checksDone > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task testReset;
        begin
            check({accelThreeWire, gyroThreeWire, accel_mag_serial_out_oe, gyro_serial_out_oe}, 4'h0);
            check(spiMode, 1'b1);
            $display("test reset done");
        end
    endtask
    task testWrite;
        begin
            i_shis_host_model.xfer(3'h1, 1'b0, 1'b0, 8'h12, 16'hA700, 1, rd);
            check(wrSeen, {3'h1, 7'h12, 8'hA7});
            check(spiModeHigh, 1'b0);
            $display("test write done");
        end
    endtask
    task testGyroBurst;
        begin
            i_shis_host_model.xfer(3'h2, 1'b1, 1'b0, 8'hA0, 16'h0, 2, rd);
            check(rd, {8'h20 ^ 8'h3C, 8'h21 ^ 8'h3C});
            check(rdSeen, {3'h2, 7'h22});
            check(spiModeHigh, 1'b1);
            $display("test gyro burst done");
        end
    endtask
    task testMag;
        begin
            i_shis_host_model.xfer(3'h4, 1'b0, 1'b0, 8'h05, 16'h3C00, 1, rd);
            check(wrSeen, {3'h4, 7'h05, 8'h3C});
            i_shis_host_model.xfer(3'h4, 1'b0, 1'b0, 8'h85, 16'h0, 1, rd);
            check(rd[7:0], 8'h05 ^ 8'hC3);
            $display("test mag done");
        end
    endtask
    task testThreeWire;
        begin
            i_shis_host_model.xfer(3'h1, 1'b0, 1'b0, 8'h34, 16'h0100, 1, rd);
            i_shis_host_model.xfer(3'h2, 1'b0, 1'b0, 8'h34, 16'h0100, 1, rd);
            check({accelThreeWire, gyroThreeWire}, 2'h3);
            i_shis_host_model.xfer(3'h1, 1'b1, 1'b1, 8'hC4, 16'h0, 1, rd);
            check(rd[7:0], 8'h44 ^ 8'h5A);
            $display("test three-wire done");
        end
    endtask
    task testI2c;
        begin
            @(posedge clk);
            protocol_select_pin <= 1'b1;
            strapAm <= 1'b1;
            i2cSdaPullLow <= 1'b1;
            i_shis_host_model.sck <= 1'b1;
            i_shis_host_model.csA <= 1'b0;
            repeat (8) @(posedge clk);
            #1;
            check({accelMagAddrLsb, gyroAddrLsb, magAddrLsb}, 3'h5);
            check(targetSel, 3'h0);
            check({spiMode, i2cSclLevel, i2cSdaLevel, shared_serial_data_oe}, 4'h5);
            @(posedge clk);
            strapAm <= 1'b0;
            strapG <= 1'b1;
            i2cSdaPullLow <= 1'b0;
            i_shis_host_model.sck <= 1'b0;
            i_shis_host_model.csM <= 1'b0;
            repeat (8) @(posedge clk);
            #1;
            check({accelMagAddrLsb, gyroAddrLsb, magAddrLsb}, 3'h2);
            check({spiMode, i2cSclLevel, i2cSdaLevel, shared_serial_data_oe}, 4'h2);
            $display("test i2c done");
        end
    endtask
    // main sequence
    initial
    begin
        {rst, protocol_select_pin, i2cSdaPullLow, strapAm, strapG, flt} = 6'b100000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #13;
        testReset;
        testWrite;
        testGyroBurst;
        testMag;
        testThreeWire;
        testI2c;
        results;
    end
    // watchdog against a hung frame
    initial
    begin
        #1000000;
        failCount++;
        results;
    end
endmodule // tb_shis_host_select

// >>> design/shis_host_select.v
// host interface selection and pin routing for a multi-sensor device
//
// How it works
// - device only answers as a slave
// - protocol pin low SPI, high I2C
// - SPI starts in four-wire form after reset
// - software may switch to three-wire data line
// - each inertial sensor has its own pins
// - accel-mag output: read data or address bit
// - gyro output: read data or address bit
// - shared data: input, bidirectional, or I2C data
// - mag select: chip select or address bit
// - accel and gyro selects ignored under I2C
// - shared clock: SPI clock or I2C clock
// - modes 00 and 11 picked automatically
// - read flag, seven address bits, eight data
`timescale 1ns/100ps
`include "shis_map.vh"
module shis_host_select (
    input wire clk,
    input wire rst,
    // pins, all from outside the clock domain
    input wire protocol_select_pin,
    input wire shared_serial_clock,
    input wire accel_select_n,
    input wire gyro_select_n,
    input wire magneto_select_n,
    input wire shared_serial_data_in,
    output wire shared_serial_data_out,
    output wire shared_serial_data_oe,
    input wire accel_mag_serial_out_in,
    output wire accel_mag_serial_out_out,
    output wire accel_mag_serial_out_oe,
    input wire gyro_serial_out_in,
    output wire gyro_serial_out_out,
    output wire gyro_serial_out_oe,
    // register side toward the sensor cores
    output wire [2:0] targetSel,
    output wire [6:0] regAddr,
    output wire [7:0] regWrData,
    output wire regWrStrobe,
    output wire regRdReq,
    input wire [7:0] accelRdData,
    input wire [7:0] gyroRdData,
    input wire [7:0] magRdData,
    // status toward the sensor cores
    output wire spiMode,
    output wire spiModeHigh,
    output wire accelThreeWire,
    output wire gyroThreeWire,
    // I2C side: line levels and address bits for the I2C engine
    output wire i2cSclLevel,
    output wire i2cSdaLevel,
    input wire i2cSdaPullLow,
    output wire accelMagAddrLsb,
    output wire gyroAddrLsb,
    output wire magAddrLsb
);
    reg [`SHIS_SYNC_W-1:0] syncA_r;
    reg [`SHIS_SYNC_W-1:0] syncB_r;
    reg sckPrev_r;
    reg [2:0] target_r;
    reg [2:0] target_nxt;
    reg accTw_r;
    reg gyrTw_r;
    reg amLsb_r;
    reg gLsb_r;
    reg mLsb_r;
    reg [7:0] rdMux;
    wire sckLevel;
    wire sckRise;
    wire sckFall;
    wire isSpi;
    wire csActive;
    wire threeWire;
    wire toAccMag;
    wire toGyro;
    wire wrStrobe;
    wire misoBit;
    wire misoOe;
    wire [6:0] addr;
    wire [7:0] wrData;

    // two-flop synchronisers for every pin input
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            syncA_r <= `SHIS_SYNC_RESET;
            syncB_r <= `SHIS_SYNC_RESET;
            sckPrev_r <= 1'b0;
        end
        else
        begin
            syncA_r <= {gyro_serial_out_in, accel_mag_serial_out_in, protocol_select_pin,
                        magneto_select_n, gyro_select_n, accel_select_n,
                        shared_serial_data_in, shared_serial_clock};
            syncB_r <= syncA_r;
            sckPrev_r <= syncB_r[`SHIS_S_SCK];
        end
    end

    // clock edges found on the second synchroniser stage
    assign sckLevel = syncB_r[`SHIS_S_SCK];
    assign sckRise = sckLevel & ~sckPrev_r;
    assign sckFall = ~sckLevel & sckPrev_r;

    // ground selects SPI, supply selects I2C; level read as static
    assign isSpi = ~syncB_r[`SHIS_S_PS];

    // select decode: any one low select names the target, SPI only
    always @*
    begin
        target_nxt = `SHIS_T_NONE;
        if (isSpi)
        begin
            if (!syncB_r[`SHIS_S_CSA])
            begin
                target_nxt = `SHIS_T_ACC;
            end
            else if (!syncB_r[`SHIS_S_CSG])
            begin
                target_nxt = `SHIS_T_GYR;
            end
            else if (!syncB_r[`SHIS_S_CSM])
            begin
                target_nxt = `SHIS_T_MAG;
            end
        end
    end

    // target register; dropping all selects ends the frame
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            target_r <= `SHIS_T_NONE;
        end
        else
        begin
            target_r <= target_nxt;
        end
    end

    assign csActive = |target_r;
    assign toAccMag = target_r[0] | target_r[2];
    assign toGyro = target_r[1];

    // read data chosen from the addressed sensor core
    always @*
    begin
        rdMux = 8'h00;
        case (target_r)
            `SHIS_T_ACC: rdMux = accelRdData;
            `SHIS_T_GYR: rdMux = gyroRdData;
            `SHIS_T_MAG: rdMux = magRdData;
            default: rdMux = 8'h00;
        endcase
    end

    // frame engine; it only answers, never starts a transfer
    shis_spi_slave i_shis_spi_slave (
        .clk(clk),
        .rst(rst),
        .csActive(csActive),
        .sckRise(sckRise),
        .sckFall(sckFall),
        .sckLevel(sckLevel),
        .mosiBit(syncB_r[`SHIS_S_SDX]),
        .rdData(rdMux),
        .regAddr_r(addr),
        .wrData_r(wrData),
        .wrStrobe_r(wrStrobe),
        .rdReq_r(regRdReq),
        .misoBit_r(misoBit),
        .misoOe(misoOe),
        .modeHigh_r(spiModeHigh)
    );

    // three-wire enable bits, four-wire after reset
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            accTw_r <= `SHIS_TW_RESET;
            gyrTw_r <= `SHIS_TW_RESET;
        end
        else if (wrStrobe && addr == `SHIS_TW_ADDR)
        begin
            if (target_r == `SHIS_T_ACC)
            begin
                accTw_r <= wrData[`SHIS_TW_BIT];
            end
            if (target_r == `SHIS_T_GYR)
            begin
                gyrTw_r <= wrData[`SHIS_TW_BIT];
            end
        end
    end

    // mag shares the accel output and follows the accel bit
    assign threeWire = toGyro ? gyrTw_r : accTw_r;

    // address bits follow the strap pins while I2C is active
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            amLsb_r <= 1'b0;
            gLsb_r <= 1'b0;
            mLsb_r <= 1'b0;
        end
        else if (!isSpi)
        begin
            amLsb_r <= syncB_r[`SHIS_S_ACCEL_MAG_SERIAL_OUT];
            gLsb_r <= syncB_r[`SHIS_S_GYRO_SERIAL_OUT];
            mLsb_r <= syncB_r[`SHIS_S_CSM];
        end
    end

    // output pins: four-wire read data on the sensor's own pin
    assign accel_mag_serial_out_out = misoBit;
    assign accel_mag_serial_out_oe = isSpi & toAccMag & ~threeWire & misoOe;
    assign gyro_serial_out_out = misoBit;
    assign gyro_serial_out_oe = isSpi & toGyro & ~threeWire & misoOe;

    // shared data: input in four-wire, turned around in three-wire, open drain in I2C
    assign shared_serial_data_out = isSpi & misoBit;
    assign shared_serial_data_oe = isSpi ? (threeWire & misoOe) : i2cSdaPullLow;

    // clock and data levels handed to the I2C engine; clock never driven
    assign i2cSclLevel = sckLevel;
    assign i2cSdaLevel = syncB_r[`SHIS_S_SDX];

    assign targetSel = target_r;
    assign regAddr = addr;
    assign regWrData = wrData;
    assign regWrStrobe = wrStrobe;
    assign spiMode = isSpi;
    assign accelThreeWire = accTw_r;
    assign gyroThreeWire = gyrTw_r;
    assign accelMagAddrLsb = amLsb_r;
    assign gyroAddrLsb = gLsb_r;
    assign magAddrLsb = mLsb_r;
endmodule // shis_host_select

// >>> design/shis_map.vh
// constants for the sensor host interface select block
`ifndef SHIS_MAP_VH
`define SHIS_MAP_VH
// register offset holding the three-wire enable bit (accel and gyro alike)
`define SHIS_TW_ADDR 7'h34
// position of the three-wire enable bit inside that register
`define SHIS_TW_BIT 0
// reset value of the three-wire enable bits: four-wire form
`define SHIS_TW_RESET 1'h0
// index of the last bit of a byte, counted from zero
`define SHIS_LAST_BIT 3'h7
// synchroniser width: clock, data, three selects, protocol, two straps
`define SHIS_SYNC_W 8
// synchroniser reset value: selects idle high, the rest low
`define SHIS_SYNC_RESET 8'h1C
// synchroniser bit positions
`define SHIS_S_SCK 0
`define SHIS_S_SDX 1
`define SHIS_S_CSA 2
`define SHIS_S_CSG 3
`define SHIS_S_CSM 4
`define SHIS_S_PS 5
`define SHIS_S_ACCEL_MAG_SERIAL_OUT 6
`define SHIS_S_GYRO_SERIAL_OUT 7
// one-hot target codes: accel, gyro, mag
`define SHIS_T_NONE 3'h0
`define SHIS_T_ACC 3'h1
`define SHIS_T_GYR 3'h2
`define SHIS_T_MAG 3'h4
`endif

// >>> design/shis_spi_slave.v
// serial frame engine: command byte, address, data bytes, read bursts
`timescale 1ns/100ps
`include "shis_map.vh"
module shis_spi_slave (
    input wire clk,
    input wire rst,
    input wire csActive,
    input wire sckRise,
    input wire sckFall,
    input wire sckLevel,
    input wire mosiBit,
    input wire [7:0] rdData,
    output reg [6:0] regAddr_r,
    output reg [7:0] wrData_r,
    output reg wrStrobe_r,
    output reg rdReq_r,
    output reg misoBit_r,
    output wire misoOe,
    output reg modeHigh_r
);
    localparam ST_IDLE = 3'h1;
    localparam ST_CMD = 3'h2;
    localparam ST_DATA = 3'h4;

    reg [2:0] state_r;
    reg [2:0] bitCnt_r;
    reg [6:0] rxSh_r;
    reg [7:0] txSh_r;
    reg isRead_r;
    reg wrDone_r;
    reg driving_r;
    wire [7:0] rxByte;

    // byte completed by the current sampling edge
    assign rxByte = {rxSh_r[6:0], mosiBit};

    // read data leaves only in the data phase of a read frame
    assign misoOe = isRead_r & driving_r & csActive & (state_r == ST_DATA);

    // frame sequencer: sample on rising, launch on falling, in both modes
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            bitCnt_r <= 3'h0;
            rxSh_r <= 7'h00;
            txSh_r <= 8'h00;
            isRead_r <= 1'b0;
            wrDone_r <= 1'b0;
            driving_r <= 1'b0;
            regAddr_r <= 7'h00;
            wrData_r <= 8'h00;
            wrStrobe_r <= 1'b0;
            rdReq_r <= 1'b0;
            misoBit_r <= 1'b0;
            modeHigh_r <= 1'b0;
        end
        else
        begin
            wrStrobe_r <= 1'b0;
            rdReq_r <= 1'b0;
            // fetch answer in the cycle the request stands
            if (rdReq_r)
            begin
                txSh_r <= rdData;
            end
            if (!csActive)
            begin
                state_r <= ST_IDLE;
                driving_r <= 1'b0;
                misoBit_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        // clock level at select fall picks mode 00 or 11
                        modeHigh_r <= sckLevel;
                        bitCnt_r <= 3'h0;
                        isRead_r <= 1'b0;
                        wrDone_r <= 1'b0;
                        state_r <= ST_CMD;
                    end
                    ST_CMD:
                    begin
                        if (sckRise)
                        begin
                            rxSh_r <= rxByte[6:0];
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (bitCnt_r == `SHIS_LAST_BIT)
                            begin
                                // first bit is read flag, then seven address bits
                                isRead_r <= rxByte[7];
                                regAddr_r <= rxByte[6:0];
                                rdReq_r <= rxByte[7];
                                state_r <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA:
                    begin
                        if (sckRise)
                        begin
                            rxSh_r <= rxByte[6:0];
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (bitCnt_r == `SHIS_LAST_BIT)
                            begin
                                if (!isRead_r && !wrDone_r)
                                begin
                                    // single write byte per frame
                                    wrData_r <= rxByte;
                                    wrStrobe_r <= 1'b1;
                                    wrDone_r <= 1'b1;
                                end
                                if (isRead_r)
                                begin
                                    // burst read: next address
                                    regAddr_r <= regAddr_r + 7'h01;
                                    rdReq_r <= 1'b1;
                                end
                            end
                        end
                        if (sckFall && isRead_r)
                        begin
                            misoBit_r <= txSh_r[7];
                            txSh_r <= {txSh_r[6:0], 1'b0};
                            driving_r <= 1'b1;
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // shis_spi_slave
